// [logic/sps_page_stack.sv]
// three-byte page context stack with apb register access
// bus timing: a setup cycle is decoded and answered one cycle later;
// pready stands for exactly that access cycle, so the slave never
// stretches a transfer. read data is captured at the setup edge and
// stands in the access cycle; a write lands only at the completing
// access edge, the one at which the master samples pready high.
//
// stack timing: the core strobes are taken at the edge where they are
// high, and the moved values are visible in the following cycle.
//
// Register access over APB is this design's own decision.
module sps_page_stack #(
    // one byte per stack entry; the register map and bus lanes assume it
    parameter int PAGE_W = 8
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire sps_pkg::sps_apb_req_s apb_req,
    output sps_pkg::sps_apb_rsp_s      apb_rsp,
    // core interrupt sequencing
    input  wire logic                  irq_entry_pulse,
    input  wire logic                  irq_return_pulse,
    // page in use by the core
    output logic [7:0]                 current_page_select,
    output logic                       auto_page_enable
);
    import sps_pkg::*;

    // register selected by the bus address
    typedef enum logic [2:0] {
        SPS_SEL_NONE    = 3'h0,
        SPS_SEL_CURRENT = 3'h1,
        SPS_SEL_SECOND  = 3'h3,
        SPS_SEL_THIRD   = 3'h2,
        SPS_SEL_CONTROL = 3'h6
    } sps_sel_e;

    // stack movement asked for by the core in this cycle
    typedef enum logic [1:0] {
        SPS_MOVE_HOLD = 2'h0,
        SPS_MOVE_PUSH = 2'h1,
        SPS_MOVE_POP  = 2'h3
    } sps_move_e;

    // the byte-wide entries and bus lanes cannot serve another width
    if (PAGE_W != SPS_DW) begin : g_width_check
        $error("sps_page_stack: PAGE_W must equal 8");
    end

    sps_state_s s_r;
    sps_state_s s_nxt;

    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    // one decoder serves both the read and the write path
    function automatic sps_sel_e decode(input logic [11:0] a);
        if (hit(a, SPS_IDX_CURRENT)) begin
            decode = SPS_SEL_CURRENT;
        end else if (hit(a, SPS_IDX_SECOND)) begin
            decode = SPS_SEL_SECOND;
        end else if (hit(a, SPS_IDX_THIRD)) begin
            decode = SPS_SEL_THIRD;
        end else if (hit(a, SPS_IDX_CONTROL)) begin
            decode = SPS_SEL_CONTROL;
        end else begin
            decode = SPS_SEL_NONE;
        end
    endfunction : decode

    // stack entry number to its register
    function automatic sps_sel_e entry_sel(input int i);
        case (i)
            0:       entry_sel = SPS_SEL_CURRENT;
            1:       entry_sel = SPS_SEL_SECOND;
            2:       entry_sel = SPS_SEL_THIRD;
            default: entry_sel = SPS_SEL_NONE;
        endcase
    endfunction : entry_sel

    // unused upper lanes read as zero
    function automatic logic [31:0] read_word(input sps_sel_e sel, input sps_state_s s);
        read_word = 32'h0000_0000;
        case (sel)
            SPS_SEL_CURRENT: read_word[7:0] = s.current_page_select;
            SPS_SEL_SECOND:  read_word[7:0] = s.page_stack_second;
            SPS_SEL_THIRD:   read_word[7:0] = s.page_stack_third;
            SPS_SEL_CONTROL: read_word[SPS_AUTO_EN_BIT] = s.auto_page_enable;
            default:         read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    logic                   setup_hit;
    logic                   access_done;
    logic                   wr_done;
    logic                   rd_setup;
    sps_sel_e               sel;
    sps_move_e              move;
    logic [SPS_ENTRIES-1:0] entry_wr;
    logic                   ctrl_wr;
    logic [7:0]             wr_byte;

    // per-entry software write strobes
    for (genvar i = 0; i < SPS_ENTRIES; i++) begin : g_entry_wr
        assign entry_wr[i] = wr_done && (sel == entry_sel(i));
    end

    always_comb begin
        setup_hit   = apb_req.psel && !apb_req.penable;
        // the access completes at the edge where our ready is high
        access_done = apb_req.psel && apb_req.penable && s_r.pready;
        wr_done     = access_done && apb_req.pwrite;
        rd_setup    = setup_hit && !apb_req.pwrite;
        sel         = decode(apb_req.paddr);
        ctrl_wr     = wr_done && (sel == SPS_SEL_CONTROL);
        wr_byte     = apb_req.pwdata[7:0];

        // entry wins if both strobes coincide; the return is then lost
        move = SPS_MOVE_HOLD;
        if (s_r.auto_page_enable) begin
            if (irq_entry_pulse) begin
                move = SPS_MOVE_PUSH;
            end else if (irq_return_pulse) begin
                move = SPS_MOVE_POP;
            end
        end

        s_nxt = s_r;

        // answer exactly one cycle after every setup
        s_nxt.pready  = setup_hit;
        s_nxt.pslverr = setup_hit && (sel == SPS_SEL_NONE);
        s_nxt.prdata  = 32'h0000_0000;
        if (rd_setup) begin
            s_nxt.prdata = read_word(sel, s_r);
        end

        // software writes first, so a shift below overrides the entry writes, except a third-entry write during a pop; a control write is never overridden
        if (entry_wr[0]) begin
            s_nxt.current_page_select = wr_byte;
        end
        if (entry_wr[1]) begin
            s_nxt.page_stack_second = wr_byte;
        end
        if (entry_wr[2]) begin
            s_nxt.page_stack_third = wr_byte;
        end
        if (ctrl_wr) begin
            s_nxt.auto_page_enable = apb_req.pwdata[SPS_AUTO_EN_BIT];
        end

        case (move)
            SPS_MOVE_PUSH: begin
                s_nxt.current_page_select = SPS_ISR_PAGE;
                s_nxt.page_stack_second   = s_r.current_page_select;
                s_nxt.page_stack_third    = s_r.page_stack_second;
            end
            SPS_MOVE_POP: begin
                // third entry keeps its value: nothing lies below it
                s_nxt.current_page_select = s_r.page_stack_second;
                s_nxt.page_stack_second   = s_r.page_stack_third;
            end
            default: begin
                s_nxt.pslverr = s_nxt.pslverr;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{current_page_select: SPS_RST_PAGE,
                     page_stack_second:   SPS_RST_SECOND,
                     page_stack_third:    SPS_RST_THIRD,
                     auto_page_enable:    SPS_RST_AUTO_EN,
                     pready:              1'b0,
                     pslverr:             1'b0,
                     prdata:              32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp.pready       = s_r.pready;
    assign apb_rsp.pslverr      = s_r.pslverr;
    assign apb_rsp.prdata       = s_r.prdata;
    assign current_page_select  = s_r.current_page_select;
    assign auto_page_enable     = s_r.auto_page_enable;
endmodule : sps_page_stack

// [logic/sps_pkg.sv]
// package for the page context stack: offsets, resets, bus carriers
package sps_pkg;
    localparam int          SPS_DW            = 8;
    localparam int          SPS_ENTRIES       = 3;
    // register offsets, not used: the decoder matches each index below times four
    localparam logic [11:0] SPS_OFF_CURRENT   = 12'h0A4;
    localparam logic [11:0] SPS_OFF_SECOND    = 12'h085;
    localparam logic [11:0] SPS_OFF_THIRD     = 12'h086;
    localparam logic [11:0] SPS_OFF_CONTROL   = 12'h0E4;
    // register indices as printed
    localparam logic [9:0]  SPS_IDX_SECOND    = 10'h085;
    localparam logic [9:0]  SPS_IDX_THIRD     = 10'h086;
    localparam logic [9:0]  SPS_IDX_CURRENT   = 10'h0A7;
    localparam logic [9:0]  SPS_IDX_CONTROL   = 10'h0E5;
    localparam logic [7:0]  SPS_RST_PAGE      = 8'h00;
    localparam logic [7:0]  SPS_RST_SECOND    = 8'h00;
    localparam logic [7:0]  SPS_RST_THIRD     = 8'h00;
    localparam logic        SPS_RST_AUTO_EN   = 1'b1;
    localparam int          SPS_AUTO_EN_BIT   = 0;
    localparam logic [7:0]  SPS_ISR_PAGE      = 8'h00;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sps_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sps_apb_rsp_s;

    typedef struct packed {
        logic [7:0]  current_page_select;
        logic [7:0]  page_stack_second;
        logic [7:0]  page_stack_third;
        logic        auto_page_enable;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sps_state_s;
endpackage : sps_pkg

// [tb/sps_core_model.sv]
// core model: one-cycle interrupt strobes
module sps_core_model (
    input wire logic pclk, presetn,
    input wire logic [1:0] req,
    output logic irq_entry_pulse, irq_return_pulse
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {irq_entry_pulse, irq_return_pulse} <= 2'b00;
        end else begin
            {irq_entry_pulse, irq_return_pulse} <= req;
        end
    end
endmodule : sps_core_model

// [tb/sps_page_stack_bench.sv]
// bench for the page stack
module sps_page_stack_bench import sps_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, irq_entry_pulse, irq_return_pulse, auto_page_enable;
    logic [1:0] req;
    logic [7:0] current_page_select;
    logic [31:0] sd = 32'hC49A;
    int num_errors = 0, n_checks = 0;
    sps_apb_req_s apb_req;
    sps_apb_rsp_s apb_rsp;
    logic [32:0] exq[$];
    sps_core_model core_u (.pclk, .presetn, .req, .irq_entry_pulse, .irq_return_pulse);
    sps_page_stack dut_u (.pclk, .presetn, .apb_req, .apb_rsp, .irq_entry_pulse,
        .irq_return_pulse, .current_page_select, .auto_page_enable);
    function automatic logic [31:0] lf(logic [31:0] s);
        return {s[30:0], ^(s & 32'h80200003)}; endfunction : lf
    task automatic chk(logic [32:0] g, e);
        n_checks++;
        if (g !== e) $display("CHECK FAILED rdata exp %h got %h", e, g);
        num_errors += int'(g !== e);
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic apb(logic w, logic [11:0] a, logic [7:0] d, logic [32:0] e = 0);
        if (!w) exq.push_back(e);
        apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge pclk) apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        apb_req <= '0;
        @(posedge pclk); // idle edge: no double drive
    endtask : apb
    task automatic irq(logic [1:0] a, b = 2'b00, c = 2'b00, d = 2'b00);
        req <= a;
        @(posedge pclk) req <= b;
        @(posedge pclk) req <= c;
        @(posedge pclk) req <= d;
        repeat (3) @(posedge pclk) req <= 2'b00;
    endtask : irq
    always @(posedge pclk) if (apb_rsp.pready === 1'b1 && !apb_req.pwrite)
        chk({apb_rsp.pslverr, apb_rsp.prdata}, exq.pop_front());
    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end
    initial #20000 begin
        num_errors++;
        print_verdict;
    end
    initial begin
        {presetn, req, apb_req} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h214, 0);
        apb(0, 12'h394, 0, 1);
        apb(1, 12'h29C, 8'h0F); irq(2'b10); apb(0, 12'h29C, 0);
        apb(0, 12'h214, 0, 8'h0F);
        apb(1, 12'h218, 8'h55); apb(1, 12'h29C, 8'h33); irq(2'b10);
        apb(0, 12'h218, 0, 8'h0F);
        apb(1, 12'h214, 8'hA1); apb(1, 12'h218, 8'h66); irq(2'b01);
        apb(0, 12'h29C, 0, 8'hA1);
        apb(0, 12'h214, 0, 8'h66);
        $display("stack test done");
        apb(1, 12'h394, 0); irq(2'b10); apb(0, 12'h29C, 0, 8'hA1);
        apb(1, 12'h394, 1); irq(2'b10, 2'b01); apb(0, 12'h29C, 0, 8'hA1);
        irq(2'b10, 2'b10, 2'b01, 2'b01); apb(0, 12'h29C, 0, 8'hA1);
        apb(0, 12'h300, 0, 33'h100000000);
        sd = lf(sd);
        apb(1, 12'h218, sd[7:0]); apb(0, 12'h218, 0, {25'h0, sd[7:0]});
        $display("access test done");
        print_verdict;
    end
endmodule : sps_page_stack_bench
bind sps_page_stack sps_page_stack_properties chk_u (.pclk, .presetn, .irq_entry_pulse,
    .irq_return_pulse, .auto_page_enable, .current_page_select, .apb_req, .apb_rsp);

// [tb/sps_page_stack_properties.sv]
// port checks for the page stack
module sps_page_stack_properties import sps_pkg::*; (
    input wire logic pclk, presetn, irq_entry_pulse, irq_return_pulse, auto_page_enable,
    input wire logic [7:0] current_page_select,
    input wire sps_pkg::sps_apb_req_s apb_req,
    input wire sps_pkg::sps_apb_rsp_s apb_rsp
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire st = apb_req.psel && !apb_req.penable;
    wire sh = auto_page_enable && (irq_entry_pulse || irq_return_pulse);
    wire acw = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    sequence s_in; irq_entry_pulse && auto_page_enable; endsequence
    sequence s_out; irq_return_pulse && !irq_entry_pulse && auto_page_enable; endsequence
    sequence s_two_in; s_in ##1 s_in; endsequence
    sequence s_two_out; s_out ##1 s_out; endsequence
    property p_rdy; st |=> apb_rsp.pready ##1 !apb_rsp.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_psh; s_in |=> current_page_select == SPS_ISR_PAGE; endproperty
    a_psh: assert property (p_psh) else $error("push");
    property p_rt; s_in ##1 s_out |=> current_page_select == $past(current_page_select, 2);
    endproperty
    a_rt: assert property (p_rt) else $error("pop");
    property p_still; !(acw && apb_req.paddr == 12'h29C) && !sh
        |=> $stable(current_page_select); endproperty
    a_still: assert property (p_still) else $error("moved");
    property p_deep; s_two_in ##1 s_two_out
        |=> current_page_select == $past(current_page_select, 4); endproperty
    a_deep: assert property (p_deep) else $error("deep");
    property p_en; acw && apb_req.paddr == 12'h394
        |=> auto_page_enable == $past(apb_req.pwdata[0]); endproperty
    a_en: assert property (p_en) else $error("enable");
endmodule : sps_page_stack_properties
